/* logic/fault_aggregator_pkg.sv */
// constants for the fault aggregator: register map, fields, reset values
// Notes on behaviour
// - software mask bit 0 ignores software panics
// - watchdog mask bit 0 ignores watchdog errors
// - stack mask bit 0 ignores stack overruns
// - loop mask bit 0 ignores loop overruns
// - any unmasked source error sets summary flag
// - flag stays set until software clears unit
// - flag is bit 0, read only
// - code register keeps first error only, read only
// - code bit 15 software, bit 14 loop
// - code bit 13 stack, bit 12 watchdog
// - code bits 11..0 memory and converter parity
// - masks other than the parity mask, flag and code reset to zero
// - rising edge on clear bit clears unit
// - parity mask resets 0x0003, one bit per source
`default_nettype none
package fault_aggregator_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [15:0] IDX_CLEAR = 16'hF421;
  localparam logic [15:0] IDX_PARITY_MASK = 16'hF422;
  localparam logic [15:0] IDX_SOFTWARE_MASK = 16'hF423;
  localparam logic [15:0] IDX_WATCHDOG_MASK = 16'hF424;
  localparam logic [15:0] IDX_STACK_MASK = 16'hF425;
  localparam logic [15:0] IDX_LOOP_MASK = 16'hF426;
  localparam logic [15:0] IDX_SUMMARY = 16'hF427;
  localparam logic [15:0] IDX_FIRST_SOURCE = 16'hF428;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hF429;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hF42A;
  // ==========================================================
  // field layout
  localparam int CLEAR_BIT = 0;
  localparam int MASK_BIT = 0;
  localparam int SUMMARY_BIT = 0;
  localparam int CODE_W = 16;
  localparam int PARITY_W = 12;
  localparam int SRC_SOFTWARE = 15;
  localparam int SRC_LOOP = 14;
  localparam int SRC_STACK = 13;
  localparam int SRC_WATCHDOG = 12;
  localparam int src_data_mem_b_bank0 = 8;
  localparam int src_data_mem_a_bank0 = 4;
  localparam int src_program_mem_a = 2;
  localparam int src_rate_converter_a = 0;
  // ==========================================================
  // reset values
  localparam logic [PARITY_W-1:0] PARITY_MASK_RESET = 12'h003;
  localparam logic MASK_RESET = 1'h0;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : fault_aggregator_pkg
`default_nettype wire

/* logic/fault_aggregator.sv */
// fault aggregator: per-source masks, sticky summary flag, first-source capture, APB slave
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fault_aggregator #(
  parameter int ADDR_W = 18
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic softwarePanicErr,
  input wire logic loopOverrunErr,
  input wire logic stackOverrunErr,
  input wire logic watchdogErr,
  input wire logic [3:0] dataMemBParityErr,
  input wire logic [3:0] dataMemAParityErr,
  input wire logic [1:0] programMemParityErr,
  input wire logic [1:0] rateConverterParityErr,
  output logic faultFlag,
  output logic [15:0] firstFaultCode,
  output logic irq
);
  // ==========================================================
  // register state
  logic clearBit;
  logic [fault_aggregator_pkg::PARITY_W-1:0] parityMask;
  logic softwareIgnore;
  logic watchdog_fault_ignore;
  logic stackIgnore;
  logic loopIgnore;
  logic [fault_aggregator_pkg::CODE_W-1:0] irqStatus;
  logic [fault_aggregator_pkg::CODE_W-1:0] irqMask;

  // ==========================================================
  // bus decode
  logic [ADDR_W-3:0] wordIdx;
  logic access;
  logic wrDone;
  logic hitClear, hitParity, hitSoftware, hitWatchdog, hitStack, hitLoop;
  logic hitSummary, hitSource, hitIrqStatus, hitIrqMask, hitAny;

  assign wordIdx = paddr[ADDR_W-1:2];
  assign access = psel & penable & ~pready;
  assign wrDone = psel & penable & pready & pwrite;

  always_comb begin
    hitClear = 1'b0;
    hitParity = 1'b0;
    hitSoftware = 1'b0;
    hitWatchdog = 1'b0;
    hitStack = 1'b0;
    hitLoop = 1'b0;
    hitSummary = 1'b0;
    hitSource = 1'b0;
    hitIrqStatus = 1'b0;
    hitIrqMask = 1'b0;
    if (wordIdx == fault_aggregator_pkg::IDX_CLEAR) begin
      hitClear = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_PARITY_MASK) begin
      hitParity = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_SOFTWARE_MASK) begin
      hitSoftware = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_WATCHDOG_MASK) begin
      hitWatchdog = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_STACK_MASK) begin
      hitStack = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_LOOP_MASK) begin
      hitLoop = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_SUMMARY) begin
      hitSummary = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_FIRST_SOURCE) begin
      hitSource = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_IRQ_STATUS) begin
      hitIrqStatus = 1'b1;
    end else if (wordIdx == fault_aggregator_pkg::IDX_IRQ_MASK) begin
      hitIrqMask = 1'b1;
    end
  end

  assign hitAny = hitClear | hitParity | hitSoftware | hitWatchdog | hitStack | hitLoop |
                  hitSummary | hitSource | hitIrqStatus | hitIrqMask;

  // ==========================================================
  // error gating
  logic [fault_aggregator_pkg::CODE_W-1:0] rawErr;
  logic [fault_aggregator_pkg::CODE_W-1:0] ignoreVec;
  logic [fault_aggregator_pkg::CODE_W-1:0] gatedErr;
  logic anyErr;

  assign rawErr = {softwarePanicErr, loopOverrunErr, stackOverrunErr, watchdogErr,
                   dataMemBParityErr, dataMemAParityErr, programMemParityErr, rateConverterParityErr};

  assign ignoreVec[fault_aggregator_pkg::PARITY_W-1:0] = parityMask;
  assign ignoreVec[fault_aggregator_pkg::SRC_WATCHDOG] = watchdog_fault_ignore;
  assign ignoreVec[fault_aggregator_pkg::SRC_STACK] = stackIgnore;
  assign ignoreVec[fault_aggregator_pkg::SRC_LOOP] = loopIgnore;
  assign ignoreVec[fault_aggregator_pkg::SRC_SOFTWARE] = softwareIgnore;

  // ==========================================================
  // per-source gate
  for (genvar b = 0; b < fault_aggregator_pkg::CODE_W; b++) begin : g_gate
    assign gatedErr[b] = rawErr[b] & ~ignoreVec[b];
  end

  assign anyErr = |gatedErr;

  // ==========================================================
  // clear edge detect
  logic clearRise;
  logic next_clearBit;

  always_comb begin
    next_clearBit = clearBit;
    if (wrDone && hitClear) begin
      next_clearBit = pwdata[fault_aggregator_pkg::CLEAR_BIT];
    end
  end

  assign clearRise = next_clearBit & ~clearBit;

  always_ff @(posedge clock) begin
    if (rst) begin
      clearBit <= 1'b0;
    end else begin
      clearBit <= next_clearBit;
    end
  end

  // ==========================================================
  // control registers, one per concern
  // software mask resets to zero
  always_ff @(posedge clock) begin
    if (rst) begin
      softwareIgnore <= fault_aggregator_pkg::MASK_RESET;
    end else if (wrDone && hitSoftware) begin
      softwareIgnore <= pwdata[fault_aggregator_pkg::MASK_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      watchdog_fault_ignore <= fault_aggregator_pkg::MASK_RESET;
    end else if (wrDone && hitWatchdog) begin
      watchdog_fault_ignore <= pwdata[fault_aggregator_pkg::MASK_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      stackIgnore <= fault_aggregator_pkg::MASK_RESET;
    end else if (wrDone && hitStack) begin
      stackIgnore <= pwdata[fault_aggregator_pkg::MASK_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      loopIgnore <= fault_aggregator_pkg::MASK_RESET;
    end else if (wrDone && hitLoop) begin
      loopIgnore <= pwdata[fault_aggregator_pkg::MASK_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      parityMask <= fault_aggregator_pkg::PARITY_MASK_RESET;
    end else if (wrDone && hitParity) begin
      parityMask <= pwdata[fault_aggregator_pkg::PARITY_W-1:0];
    end
  end

  // interrupt mask, one blocks a source
  always_ff @(posedge clock) begin
    if (rst) begin
      irqMask <= fault_aggregator_pkg::CODE_RESET;
    end else if (wrDone && hitIrqMask) begin
      irqMask <= pwdata[fault_aggregator_pkg::CODE_W-1:0];
    end
  end

  // ==========================================================
  // summary flag
  always_ff @(posedge clock) begin
    if (rst) begin
      faultFlag <= 1'b0;
    end else if (anyErr) begin
      faultFlag <= 1'b1;
    end else if (clearRise) begin
      faultFlag <= 1'b0;
    end
  end

  // ==========================================================
  // first source capture
  logic codeEmpty;
  assign codeEmpty = ~|firstFaultCode;

  always_ff @(posedge clock) begin
    if (rst) begin
      firstFaultCode <= fault_aggregator_pkg::CODE_RESET;
    end else if (clearRise) begin
      // clear zeroes code, new error caught
      firstFaultCode <= gatedErr;
    end else if (codeEmpty && anyErr) begin
      firstFaultCode <= gatedErr;
    end
  end

  // ==========================================================
  // interrupt status and output
  logic [fault_aggregator_pkg::CODE_W-1:0] next_irqStatus;
  logic statusClear;

  assign statusClear = wrDone & hitIrqStatus;

  for (genvar b = 0; b < fault_aggregator_pkg::CODE_W; b++) begin : g_irq_status
    // set wins over a write-one clear
    assign next_irqStatus[b] = gatedErr[b] | (irqStatus[b] & ~(statusClear & pwdata[b]));

    always_ff @(posedge clock) begin
      if (rst) begin
        irqStatus[b] <= fault_aggregator_pkg::CODE_RESET[b];
      end else begin
        irqStatus[b] <= next_irqStatus[b];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irqStatus & ~irqMask);
    end
  end

  // ==========================================================
  // read data and handshake
  logic [31:0] readMux;

  always_comb begin
    readMux = fault_aggregator_pkg::READ_ZERO;
    if (hitClear) begin
      readMux[fault_aggregator_pkg::CLEAR_BIT] = clearBit;
    end else if (hitParity) begin
      readMux[fault_aggregator_pkg::PARITY_W-1:0] = parityMask;
    end else if (hitSoftware) begin
      readMux[fault_aggregator_pkg::MASK_BIT] = softwareIgnore;
    end else if (hitWatchdog) begin
      readMux[fault_aggregator_pkg::MASK_BIT] = watchdog_fault_ignore;
    end else if (hitStack) begin
      readMux[fault_aggregator_pkg::MASK_BIT] = stackIgnore;
    end else if (hitLoop) begin
      readMux[fault_aggregator_pkg::MASK_BIT] = loopIgnore;
    end else if (hitSummary) begin
      readMux[fault_aggregator_pkg::SUMMARY_BIT] = faultFlag;
    end else if (hitSource) begin
      readMux[fault_aggregator_pkg::CODE_W-1:0] = firstFaultCode;
    end else if (hitIrqStatus) begin
      readMux[fault_aggregator_pkg::CODE_W-1:0] = irqStatus;
    end else if (hitIrqMask) begin
      readMux[fault_aggregator_pkg::CODE_W-1:0] = irqMask;
    end
  end

  // ready one cycle into the access phase
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= access;
    end
  end

  // unmapped index answers with an error
  always_ff @(posedge clock) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~hitAny;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= fault_aggregator_pkg::READ_ZERO;
    end else if (access && !pwrite) begin
      prdata <= readMux;
    end
  end
endmodule : fault_aggregator
`default_nettype wire

/* verif/fault_aggregator_assertions.sv */
// checker for the fault aggregator ports
`timescale 1ns/1ns
`default_nettype none
module fault_aggregator_assertions #(
  parameter int ADDR_W = 18
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic softwarePanicErr,
  input wire logic loopOverrunErr,
  input wire logic stackOverrunErr,
  input wire logic watchdogErr,
  input wire logic [3:0] dataMemBParityErr,
  input wire logic [3:0] dataMemAParityErr,
  input wire logic [1:0] programMemParityErr,
  input wire logic [1:0] rateConverterParityErr,
  input wire logic faultFlag,
  input wire logic [15:0] firstFaultCode
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================
  // helpers
  wire logic [15:0] errVec = {softwarePanicErr, loopOverrunErr, stackOverrunErr, watchdogErr,
    dataMemBParityErr, dataMemAParityErr, programMemParityErr, rateConverterParityErr};
  wire logic [15:0] idx = paddr[ADDR_W-1:2];
  wire logic done = psel && penable && pready;
  wire logic clrW = done && pwrite && idx == fault_aggregator_pkg::IDX_CLEAR && pwdata[0];
  logic lastClr;
  always_ff @(posedge clock) begin
    if (rst) lastClr <= 1'b0;
    else if (done && pwrite && idx == fault_aggregator_pkg::IDX_CLEAR) lastClr <= pwdata[0];
  end
  sequence clrRise;
    clrW && !lastClr && errVec == 16'h0000;
  endsequence
  sequence rdDone(logic [15:0] i);
    done && !pwrite && idx == i;
  endsequence
  // ==========================================
  // properties
  a_flag_cause: assert property ($rose(faultFlag) |-> $past(|errVec))
    else $error("flag rose without an error input");
  a_flag_sticky: assert property ($fell(faultFlag) |-> $past(clrW))
    else $error("flag fell without a clear write");
  a_flag_code: assert property (firstFaultCode != 16'h0000 |-> faultFlag)
    else $error("code set while flag low");
  a_code_hold: assert property (firstFaultCode != 16'h0000 && !clrW |=> $stable(firstFaultCode))
    else $error("code changed before clear");
  a_code_cause: assert property ($changed(firstFaultCode) && firstFaultCode != 16'h0000 |->
    (firstFaultCode & ~$past(errVec)) == 16'h0000)
    else $error("code bit without its source");
  a_clear_zero: assert property (clrRise |=> !faultFlag && firstFaultCode == 16'h0000)
    else $error("clear did not zero flag and code");
  a_flag_read: assert property (rdDone(fault_aggregator_pkg::IDX_SUMMARY) |->
    prdata == {31'h0, $past(faultFlag)})
    else $error("summary read differs from flag");
  a_code_read: assert property (rdDone(fault_aggregator_pkg::IDX_FIRST_SOURCE) |->
    prdata == {16'h0, $past(firstFaultCode)})
    else $error("code read differs from code");
endmodule : fault_aggregator_assertions
bind fault_aggregator fault_aggregator_assertions #(.ADDR_W(ADDR_W)) u_chk (.clock, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .softwarePanicErr, .loopOverrunErr, .stackOverrunErr,
  .watchdogErr, .dataMemBParityErr, .dataMemAParityErr, .programMemParityErr, .rateConverterParityErr,
  .faultFlag, .firstFaultCode);
`default_nettype wire

/* verif/fault_source_model.sv */
// error sources: one code bit per source line
`timescale 1ns/1ns
`default_nettype none
module fault_source_model (
  input wire logic [15:0] fire,
  output logic softwarePanicErr,
  output logic loopOverrunErr,
  output logic stackOverrunErr,
  output logic watchdogErr,
  output logic [3:0] dataMemBParityErr,
  output logic [3:0] dataMemAParityErr,
  output logic [1:0] programMemParityErr,
  output logic [1:0] rateConverterParityErr
);
  assign {softwarePanicErr, loopOverrunErr, stackOverrunErr, watchdogErr} = fire[15:12];
  assign {dataMemBParityErr, dataMemAParityErr, programMemParityErr, rateConverterParityErr} = fire[11:0];
endmodule : fault_source_model
`default_nettype wire

/* verif/tb_fault_aggregator.sv */
// bench for the fault aggregator
`timescale 1ns/1ns
`default_nettype none
module tb_fault_aggregator;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, faultFlag, irq, se;
  logic softwarePanicErr, loopOverrunErr, stackOverrunErr, watchdogErr;
  logic [3:0] dataMemBParityErr, dataMemAParityErr;
  logic [1:0] programMemParityErr, rateConverterParityErr;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] fire = 0, firstFaultCode;
  logic [15:0] mi[5] = '{16'hF423, 16'hF426, 16'hF425, 16'hF424, 16'hF422};
  logic [15:0] cb[5] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800};
  logic [31:0] mv[5] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h800};
  int num_errors = 0, checked = 0;
  initial forever #4 clock = ~clock;
  fault_source_model u_src (.fire, .softwarePanicErr, .loopOverrunErr, .stackOverrunErr, .watchdogErr,
    .dataMemBParityErr, .dataMemAParityErr, .programMemParityErr, .rateConverterParityErr);
  fault_aggregator u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .softwarePanicErr, .loopOverrunErr, .stackOverrunErr, .watchdogErr, .dataMemBParityErr,
    .dataMemAParityErr, .programMemParityErr, .rateConverterParityErr, .faultFlag, .firstFaultCode, .irq);
  task results;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] v);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= v;
    @(posedge clock) penable <= 1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      results;
    end
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask : apb
  task pulse(input logic [15:0] c);
    fire <= c;
    @(posedge clock) fire <= 0;
    repeat (3) @(posedge clock);
  endtask : pulse
  task clr;
    apb(1, 16'hF421, 32'h1);
    apb(1, 16'hF421, 32'h0);
  endtask : clr
  initial begin
    repeat (4) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      apb(0, 16'(32'hF421 + i), 0);
      check(rd, i == 1 ? 32'h3 : 32'h0);
    end
    apb(0, 16'hF430, 0);
    check(se, 1);
    check(rd, 0);
    pulse(16'h0001);
    check({faultFlag, firstFaultCode}, 0);
    $display("done: reset values");
    for (int i = 0; i < 5; i++) begin
      apb(1, mi[i], mv[i]);
      pulse(cb[i]);
      check({faultFlag, firstFaultCode}, 0);
      apb(1, mi[i], 0);
      pulse(cb[i]);
      apb(0, 16'hF428, 0);
      check(rd, cb[i]);
      apb(0, 16'hF427, 0);
      check(rd, 1);
      clr;
      check({faultFlag, firstFaultCode}, 0);
    end
    pulse(16'h0FFF);
    check(firstFaultCode, 16'h0FFF);
    clr;
    apb(1, 16'hF429, 32'hFFFF);
    $display("done: masks and codes");
    pulse(16'h2000);
    pulse(16'h1000);
    apb(1, 16'hF428, 32'hFFFF);
    apb(1, 16'hF427, 32'h0);
    check({faultFlag, firstFaultCode}, 17'h12000);
    check(irq, 1);
    apb(0, 16'hF429, 0);
    check(rd, 32'h3000);
    apb(1, 16'hF42A, 32'hFFFF);
    @(posedge clock);
    check(irq, 0);
    apb(1, 16'hF42A, 32'h0);
    @(posedge clock);
    check(irq, 1);
    apb(1, 16'hF429, 32'hFFFF);
    check(irq, 0);
    apb(1, 16'hF421, 32'h1);
    pulse(16'h1000);
    apb(1, 16'hF421, 32'h1);
    check({faultFlag, firstFaultCode}, 17'h11000);
    apb(1, 16'hF421, 32'h0);
    $display("done: capture and interrupt");
    results;
  end
endmodule : tb_fault_aggregator
`default_nettype wire
